// File: shared/cjdp_consts.vh
// Constants for the debug and test port block
`ifndef CJDP_CONSTS_VH
`define CJDP_CONSTS_VH

// Length of a self-driven reset pulse, in system clocks
`define CJDP_RST_DRIVE_CYCLES 10'h200
`define CJDP_RST_CNT_W 10
`define CJDP_RST_CNT_ONE 10'h001
`define CJDP_RST_CNT_ZERO 10'h000

// Test access port state codes
`define CJDP_ST_W 4
`define CJDP_ST_RESET 4'h0
`define CJDP_ST_IDLE 4'h1
`define CJDP_ST_SEL_DR 4'h2
`define CJDP_ST_CAP_DR 4'h3
`define CJDP_ST_SHF_DR 4'h4
`define CJDP_ST_EX1_DR 4'h5
`define CJDP_ST_PAU_DR 4'h6
`define CJDP_ST_EX2_DR 4'h7
`define CJDP_ST_UPD_DR 4'h8
`define CJDP_ST_SEL_IR 4'h9
`define CJDP_ST_CAP_IR 4'ha
`define CJDP_ST_SHF_IR 4'hb
`define CJDP_ST_EX1_IR 4'hc
`define CJDP_ST_PAU_IR 4'hd
`define CJDP_ST_EX2_IR 4'he
`define CJDP_ST_UPD_IR 4'hf

// Instruction register
`define CJDP_IR_W 2
`define CJDP_IR_CAPTURE 2'h1
`define CJDP_IR_STATUS 2'h1
`define CJDP_IR_BYPASS 2'h3
`define CJDP_IR_RESET 2'h3

// Status data register: {checkstop, quiesce, hard seq, soft seq}
`define CJDP_STAT_W 4

`endif

// File: core/cjdp_rst_drv.v
// Open-drain reset pulse generator holding a line low for a fixed count
`timescale 1ns/10ps
`default_nettype none
`include "cjdp_consts.vh"

module cjdp_rst_drv (
  input wire core_clk,
  input wire resetn,
  input wire start,
  output wire drive
);

  reg [`CJDP_RST_CNT_W-1:0] cnt_ff;
  reg [`CJDP_RST_CNT_W-1:0] nxt_cnt;

  // --------------------------------------------------------------
  // Down counter
  // --------------------------------------------------------------
  // A start while busy is ignored so the pulse never stretches
  always @* begin
    nxt_cnt = cnt_ff;
    if (cnt_ff != `CJDP_RST_CNT_ZERO) begin
      nxt_cnt = cnt_ff - `CJDP_RST_CNT_ONE;
    end else if (start) begin
      nxt_cnt = `CJDP_RST_DRIVE_CYCLES;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= `CJDP_RST_CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Exactly the full count of cycles with the line pulled low
  assign drive = (cnt_ff != `CJDP_RST_CNT_ZERO);

endmodule
`default_nettype wire

// File: core/cjdp_port.v
// Processor debug and test port: JTAG pins, reset lines, status pins
`timescale 1ns/10ps
`default_nettype none
`include "cjdp_consts.vh"

// Notes on behaviour
// [RULE1] Low test reset input holds the JTAG logic in reset.
// [RULE2] Undriven test reset reads low, so JTAG logic stays reset.
// [RULE3] Quiesce request output goes low when the core wants low power.
// [RULE4] Test data changes on falling TCK, sampled on rising TCK.
// [RULE5] TMS is sampled on rising TCK to advance the JTAG state machine.
// [RULE6] Soft reset assertion gives the core a non-maskable reset event.
// [RULE7] Device may pull soft reset low for 512 system clocks.
// [RULE8] Outside parties only pull soft reset low or release it.
// [RULE9] External hard reset assertion starts the hard-reset sequence.
// [RULE10] Device pulls hard reset low for 512 system clocks.
// [RULE11] Outside tools only pull hard reset low or release it.
// [RULE12] Pin 15 as check-stop output goes low on core check-stop.
// [RULE13] Serial test data output is driven on falling TCK.
// [RULE14] Tool treats reset lines as wired-AND and waits for release.
module cjdp_port (
  input wire core_clk,
  input wire resetn,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output wire tdo,
  output wire tdo_oe,
  input wire core_quiesce_req,
  output wire quiesce_request_n,
  input wire core_checkstop,
  input wire checkstop_sel,
  input wire shared_bus_pin_n,
  output wire checkstop_out_n,
  input wire soft_reset_n_in,
  output wire soft_reset_n_out,
  output wire soft_reset_n_oe,
  input wire core_soft_reset_req,
  output wire core_soft_reset_nmi,
  input wire hard_reset_n_in,
  output wire hard_reset_n_out,
  output wire hard_reset_n_oe,
  output wire core_hard_reset,
  output wire jtag_in_reset
);

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  reg [2:0] tck_sync_ff;
  reg [1:0] tms_sync_ff;
  reg [1:0] tdi_sync_ff;
  reg [1:0] trst_sync_ff;
  reg [2:0] srst_sync_ff;
  reg [2:0] hrst_sync_ff;
  reg [1:0] qui_sync_ff;
  reg [`CJDP_ST_W-1:0] tap_ff;
  reg [`CJDP_ST_W-1:0] nxt_tap;
  reg [`CJDP_IR_W-1:0] ir_ff;
  reg [`CJDP_IR_W-1:0] ir_shift_ff;
  reg [`CJDP_STAT_W-1:0] dr_shift_ff;
  reg bypass_ff;
  reg tdo_ff;
  reg tdo_oe_ff;
  reg quiesce_n_ff;
  reg ckstp_n_ff;
  reg nmi_ff;
  wire tck_rise;
  wire tck_fall;
  wire tms_s;
  wire tdi_s;
  wire trst_s;
  wire srst_fall;
  wire hrst_fall;
  wire soft_drive;
  wire hard_drive;
  wire soft_start;
  wire hard_start;
  wire [`CJDP_STAT_W-1:0] status_word;

  // True on a high-to-low step between two synchronised samples
  function fell;
    input [1:0] s;
    begin
      fell = s[1] & ~s[0];
    end
  endfunction

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  // Every pin but shared_bus_pin_n passes two flops; a third stage feeds the edge detectors
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tck_sync_ff <= 3'h7;
      tms_sync_ff <= 2'h3;
      tdi_sync_ff <= 2'h3;
      trst_sync_ff <= 2'h0;
      srst_sync_ff <= 3'h7;
      hrst_sync_ff <= 3'h7;
      qui_sync_ff <= 2'h0;
    end else begin
      tck_sync_ff <= {tck_sync_ff[1:0], tck};
      tms_sync_ff <= {tms_sync_ff[0], tms};
      tdi_sync_ff <= {tdi_sync_ff[0], tdi};
      trst_sync_ff <= {trst_sync_ff[0], trst_n};
      srst_sync_ff <= {srst_sync_ff[1:0], soft_reset_n_in};
      hrst_sync_ff <= {hrst_sync_ff[1:0], hard_reset_n_in};
      qui_sync_ff <= {qui_sync_ff[0], core_quiesce_req};
    end
  end

  assign tck_rise = fell(~tck_sync_ff[2:1]);
  assign tck_fall = fell(tck_sync_ff[2:1]);
  assign tms_s = tms_sync_ff[1];
  assign tdi_s = tdi_sync_ff[1];
  // A floating test reset is pulled low on the board, so reset holds
  assign trst_s = trst_sync_ff[1]; // [RULE2]
  assign srst_fall = fell(srst_sync_ff[2:1]);
  assign hrst_fall = fell(hrst_sync_ff[2:1]);
  assign jtag_in_reset = ~trst_s | (tap_ff == `CJDP_ST_RESET);

  // --------------------------------------------------------------
  // Test access port state machine
  // --------------------------------------------------------------
  always @* begin
    case (tap_ff)
      `CJDP_ST_RESET:
        nxt_tap = tms_s ? `CJDP_ST_RESET : `CJDP_ST_IDLE;
      `CJDP_ST_IDLE:
        nxt_tap = tms_s ? `CJDP_ST_SEL_DR : `CJDP_ST_IDLE;
      `CJDP_ST_SEL_DR:
        nxt_tap = tms_s ? `CJDP_ST_SEL_IR : `CJDP_ST_CAP_DR;
      `CJDP_ST_CAP_DR:
        nxt_tap = tms_s ? `CJDP_ST_EX1_DR : `CJDP_ST_SHF_DR;
      `CJDP_ST_SHF_DR:
        nxt_tap = tms_s ? `CJDP_ST_EX1_DR : `CJDP_ST_SHF_DR;
      `CJDP_ST_EX1_DR:
        nxt_tap = tms_s ? `CJDP_ST_UPD_DR : `CJDP_ST_PAU_DR;
      `CJDP_ST_PAU_DR:
        nxt_tap = tms_s ? `CJDP_ST_EX2_DR : `CJDP_ST_PAU_DR;
      `CJDP_ST_EX2_DR:
        nxt_tap = tms_s ? `CJDP_ST_UPD_DR : `CJDP_ST_SHF_DR;
      `CJDP_ST_UPD_DR:
        nxt_tap = tms_s ? `CJDP_ST_SEL_DR : `CJDP_ST_IDLE;
      `CJDP_ST_SEL_IR:
        nxt_tap = tms_s ? `CJDP_ST_RESET : `CJDP_ST_CAP_IR;
      `CJDP_ST_CAP_IR:
        nxt_tap = tms_s ? `CJDP_ST_EX1_IR : `CJDP_ST_SHF_IR;
      `CJDP_ST_SHF_IR:
        nxt_tap = tms_s ? `CJDP_ST_EX1_IR : `CJDP_ST_SHF_IR;
      `CJDP_ST_EX1_IR:
        nxt_tap = tms_s ? `CJDP_ST_UPD_IR : `CJDP_ST_PAU_IR;
      `CJDP_ST_PAU_IR:
        nxt_tap = tms_s ? `CJDP_ST_EX2_IR : `CJDP_ST_PAU_IR;
      `CJDP_ST_EX2_IR:
        nxt_tap = tms_s ? `CJDP_ST_UPD_IR : `CJDP_ST_SHF_IR;
      `CJDP_ST_UPD_IR:
        nxt_tap = tms_s ? `CJDP_ST_SEL_DR : `CJDP_ST_IDLE;
      default:
        nxt_tap = `CJDP_ST_RESET;
    endcase
  end

  // TMS only acts on a rising TCK; low test reset overrides everything
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tap_ff <= `CJDP_ST_RESET;
    end else if (!trst_s) begin
      tap_ff <= `CJDP_ST_RESET; // [RULE1]
    end else if (tck_rise) begin
      tap_ff <= nxt_tap; // [RULE5]
    end
  end

  // --------------------------------------------------------------
  // Instruction and data registers, sampled on rising TCK
  // --------------------------------------------------------------
  assign status_word = {~ckstp_n_ff, ~quiesce_n_ff, hard_drive, soft_drive};

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ir_ff <= `CJDP_IR_RESET;
      ir_shift_ff <= `CJDP_IR_CAPTURE;
      dr_shift_ff <= {`CJDP_STAT_W{1'b0}};
      bypass_ff <= 1'b0;
    end else if (!trst_s || (tap_ff == `CJDP_ST_RESET)) begin
      ir_ff <= `CJDP_IR_RESET; // [RULE1]
      ir_shift_ff <= `CJDP_IR_CAPTURE;
      bypass_ff <= 1'b0;
    end else if (tck_rise) begin
      // Capture, shift and update all happen on the rising edge
      case (tap_ff)
        `CJDP_ST_CAP_IR: begin
          ir_shift_ff <= `CJDP_IR_CAPTURE;
        end
        `CJDP_ST_SHF_IR: begin
          ir_shift_ff <= {tdi_s, ir_shift_ff[`CJDP_IR_W-1:1]}; // [RULE4]
        end
        `CJDP_ST_UPD_IR: begin
          ir_ff <= ir_shift_ff;
        end
        `CJDP_ST_CAP_DR: begin
          dr_shift_ff <= status_word;
          bypass_ff <= 1'b0;
        end
        `CJDP_ST_SHF_DR: begin
          dr_shift_ff <= {tdi_s, dr_shift_ff[`CJDP_STAT_W-1:1]}; // [RULE4]
          bypass_ff <= tdi_s;
        end
        default: begin
          bypass_ff <= bypass_ff;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Serial output, launched on falling TCK
  // --------------------------------------------------------------
  // Launching on falling TCK gives the tool half a TCK period, less the two to three
  // core clocks of synchroniser delay, of setup before its own rising-edge sample
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (!trst_s) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_ff <= (tap_ff == `CJDP_ST_SHF_IR) ||
                   (tap_ff == `CJDP_ST_SHF_DR); // [RULE13]
      if (tap_ff == `CJDP_ST_SHF_IR) begin
        tdo_ff <= ir_shift_ff[0]; // [RULE4]
      end else if (ir_ff == `CJDP_IR_STATUS) begin
        tdo_ff <= dr_shift_ff[0]; // [RULE13]
      end else begin
        tdo_ff <= bypass_ff;
      end
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // --------------------------------------------------------------
  // Quiesce request and pin 15
  // --------------------------------------------------------------
  // Registered so the pins never glitch on core-side decode
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      quiesce_n_ff <= 1'b1;
      ckstp_n_ff <= 1'b1;
    end else begin
      quiesce_n_ff <= ~qui_sync_ff[1]; // [RULE3]
      if (checkstop_sel) begin
        ckstp_n_ff <= ~core_checkstop; // [RULE12]
      end else begin
        ckstp_n_ff <= shared_bus_pin_n;
      end
    end
  end

  assign quiesce_request_n = quiesce_n_ff;
  assign checkstop_out_n = ckstp_n_ff;

  // --------------------------------------------------------------
  // Soft reset line
  // --------------------------------------------------------------
  // Only a high-to-low step counts, so the line rising after our own
  // pulse never retriggers; own-driven edges are ignored
  assign soft_start = core_soft_reset_req |
                      (srst_fall & ~soft_drive); // [RULE7]

  cjdp_rst_drv u_soft_drv (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(soft_start),
    .drive(soft_drive)
  );

  // One-cycle non-maskable reset event to the core
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      nmi_ff <= 1'b0;
    end else begin
      nmi_ff <= srst_fall; // [RULE6]
    end
  end

  assign core_soft_reset_nmi = nmi_ff;
  // Open drain: drive zero or release, never high; outside parties
  // share the wire the same way
  assign soft_reset_n_out = 1'b0; // [RULE8]
  assign soft_reset_n_oe = soft_drive; // [RULE7]

  // --------------------------------------------------------------
  // Hard reset line
  // --------------------------------------------------------------
  assign hard_start = hrst_fall & ~hard_drive; // [RULE9]

  cjdp_rst_drv u_hard_drv (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(hard_start),
    .drive(hard_drive)
  );

  assign core_hard_reset = hard_drive; // [RULE10]
  // The wire is wired-AND; tools wait for release before debug
  assign hard_reset_n_out = 1'b0; // [RULE11] [RULE14]
  assign hard_reset_n_oe = hard_drive; // [RULE10]

endmodule
`default_nettype wire

// File: verification/cjdp_checker.sv
// Port-level assertions for the debug and test port
`timescale 1ns/10ps
`default_nettype none
module cjdp_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic jtag_in_reset,
  input wire logic core_quiesce_req,
  input wire logic quiesce_request_n,
  input wire logic core_checkstop,
  input wire logic checkstop_sel,
  input wire logic shared_bus_pin_n,
  input wire logic checkstop_out_n,
  input wire logic soft_reset_n_in,
  input wire logic soft_reset_n_out,
  input wire logic soft_reset_n_oe,
  input wire logic core_soft_reset_nmi,
  input wire logic hard_reset_n_in,
  input wire logic hard_reset_n_out,
  input wire logic hard_reset_n_oe,
  input wire logic core_hard_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [10:0] s_cnt_ff;
  logic [10:0] h_cnt_ff;
  // Cycles each reset line has been pulled by the device so far
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_cnt_ff <= 11'h000;
      h_cnt_ff <= 11'h000;
    end else begin
      s_cnt_ff <= soft_reset_n_oe ? s_cnt_ff + 11'h001 : 11'h000;
      h_cnt_ff <= hard_reset_n_oe ? h_cnt_ff + 11'h001 : 11'h000;
    end
  end
  // An outside pull seen while the device is quiet starts a sequence
  sequence s_hard_fall;
    $fell(hard_reset_n_in) && !hard_reset_n_oe;
  endsequence
  sequence s_hard_drive;
    ##[2:8] hard_reset_n_oe;
  endsequence
  a_trst_reset: assert property ((!trst_n) [*4] |->
    jtag_in_reset && !tdo_oe) else $error("tap not reset");
  a_quiesce_low: assert property (core_quiesce_req [*5] |->
    !quiesce_request_n) else $error("quiesce not low");
  a_quiesce_high: assert property ((!core_quiesce_req) [*5] |->
    quiesce_request_n) else $error("quiesce not high");
  a_ckstp_follow: assert property (1'b1 |=> checkstop_out_n ==
    ($past(checkstop_sel) ? !$past(core_checkstop) :
    $past(shared_bus_pin_n))) else $error("pin 15 wrong");
  a_soft_len: assert property ($fell(soft_reset_n_oe) |->
    s_cnt_ff == 11'h200) else $error("soft pulse length");
  a_soft_hold: assert property (soft_reset_n_oe |-> s_cnt_ff < 11'h200
    && !soft_reset_n_out) else $error("soft drive");
  a_hard_len: assert property ($fell(hard_reset_n_oe) |->
    h_cnt_ff == 11'h200) else $error("hard pulse length");
  a_hard_hold: assert property (hard_reset_n_oe |-> !hard_reset_n_out
    && core_hard_reset) else $error("hard drive");
  a_hard_start: assert property (s_hard_fall |-> s_hard_drive)
    else $error("hard sequence not started");
  a_nmi_on_fall: assert property ($fell(soft_reset_n_in) |->
    ##[2:6] core_soft_reset_nmi) else $error("no nmi");
  a_tdo_on_fall: assert property ($changed(tdo) && $past(trst_n, 3)
    |-> !$past(tck, 2)) else $error("tdo off fall");
endmodule
bind cjdp_port cjdp_chk chk_i (.*);
`default_nettype wire

// File: verification/cjdp_station.sv
// Model of the external debug station on the test connector
`timescale 1ns/10ps
`default_nettype none
module cjdp_station (
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  output logic soft_pull,
  output logic hard_pull
);
  // Test clock idles high and stands still between frames
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
    soft_pull = 1'b0;
    hard_pull = 1'b0;
  end
  // Released test reset reads low through the board pull-down
  task automatic set_trst(input logic drive);
    trst_n = drive;
  endtask
  // One test clock period: change on the fall, sample on the rise
  task automatic bit_io(input logic m, input logic d, output logic q);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #32;
    tck = 1'b1;
    q = tdo;
    #32;
  endtask
  // Open-drain pulse: pull low, then release, never drive high
  task automatic od_pulse(input logic hard);
    if (hard) begin
      hard_pull = 1'b1;
    end else begin
      soft_pull = 1'b1;
    end
    #80;
    hard_pull = 1'b0;
    soft_pull = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench for the debug and test port
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic core_clk, resetn, core_quiesce_req, core_checkstop;
  logic checkstop_sel, shared_bus_pin_n, core_soft_reset_req;
  wire tck, tms, tdi, trst_n, soft_pull, hard_pull, tdo, tdo_oe;
  wire quiesce_request_n, checkstop_out_n, core_soft_reset_nmi;
  wire soft_reset_n_out, soft_reset_n_oe, hard_reset_n_out;
  wire hard_reset_n_oe, core_hard_reset, jtag_in_reset;
  wire soft_reset_n_in, hard_reset_n_in;
  int fails = 0, check_count = 0, cycles = 0, nmi_cnt = 0;
  // Pulled-up wires: low while any party pulls
  assign soft_reset_n_in = (soft_reset_n_oe ? soft_reset_n_out : 1'b1)
    && !soft_pull;
  assign hard_reset_n_in = (hard_reset_n_oe ? hard_reset_n_out : 1'b1)
    && !hard_pull;
  cjdp_port cjdp_port_i (.*);
  cjdp_station cjdp_station_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Cycle count for the hang guard, NMI pulses counted on the way
  always @(negedge core_clk) begin
    cycles++;
    if (core_soft_reset_nmi === 1'b1) nmi_cnt++;
    if (cycles == 10000) begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Time a device drive: wait for it, then count its cycles
  task automatic pulse_len(input logic hard, output int n);
    n = 0;
    for (int i = 0; i < 20 && !(hard ? hard_reset_n_oe :
        soft_reset_n_oe); i++) @(negedge core_clk);
    while ((hard ? hard_reset_n_oe : soft_reset_n_oe) === 1'b1
        && n < 600) begin
      n++;
      @(negedge core_clk);
    end
  endtask
  // Load the status instruction and read the status register
  task automatic t_jtag;
    logic q;
    logic [1:0] ir;
    logic [3:0] st;
    core_quiesce_req = 1'b1;
    core_checkstop = 1'b1;
    checkstop_sel = 1'b1;
    check(jtag_in_reset === 1'b1, "tap free w/o trst");
    cjdp_station_i.set_trst(1'b1);
    repeat (4) @(negedge core_clk);
    cjdp_station_i.bit_io(1'b0, 1'b0, q);
    repeat (2) @(negedge core_clk);
    check(jtag_in_reset === 1'b0, "tap not idle");
    // Default instruction is bypass: one-bit delay through Shift-DR
    for (int i = 0; i < 3; i++) cjdp_station_i.bit_io(i == 0, 1'b0, q);
    cjdp_station_i.bit_io(1'b0, 1'b1, ir[0]);
    cjdp_station_i.bit_io(1'b1, 1'b0, ir[1]);
    check(ir === 2'h2, "bypass path");
    cjdp_station_i.bit_io(1'b1, 1'b0, q);
    for (int i = 0; i < 4; i++) cjdp_station_i.bit_io(i < 2, 1'b0, q);
    cjdp_station_i.bit_io(1'b0, 1'b1, ir[0]);
    cjdp_station_i.bit_io(1'b1, 1'b0, ir[1]);
    check(ir === 2'h1, "ir capture");
    for (int i = 0; i < 5; i++)
      cjdp_station_i.bit_io(i == 0 || i == 3, 1'b0, q);
    cjdp_station_i.bit_io(1'b0, 1'b0, q);
    for (int i = 0; i < 4; i++) cjdp_station_i.bit_io(i == 3, 1'b0, st[i]);
    check(st === 4'hc, "status shift");
    cjdp_station_i.bit_io(1'b1, 1'b0, q);
    cjdp_station_i.bit_io(1'b0, 1'b0, q);
    cjdp_station_i.set_trst(1'b0);
    repeat (4) @(negedge core_clk);
    check(jtag_in_reset === 1'b1 && tdo_oe === 1'b0, "trst");
  endtask
  // Quiesce output and every pin 15 select/value combination
  task automatic t_pins;
    check(quiesce_request_n === 1'b0, "quiesce low");
    core_quiesce_req = 1'b0;
    repeat (5) @(negedge core_clk);
    check(quiesce_request_n === 1'b1, "quiesce high");
    for (int i = 0; i < 8; i++) begin
      {checkstop_sel, core_checkstop, shared_bus_pin_n} = i[2:0];
      repeat (2) @(negedge core_clk);
      check(checkstop_out_n === (i[2] ? !i[1] : i[0]), "pin 15");
    end
  endtask
  // Core-requested then outside-started soft reset sequences
  task automatic t_soft;
    int n, n0;
    core_soft_reset_req = 1'b1;
    @(negedge core_clk);
    core_soft_reset_req = 1'b0;
    pulse_len(1'b0, n);
    check(n == 512, "soft drive length");
    check(nmi_cnt == 1, "own pulse nmi");
    n0 = nmi_cnt;
    // Let the wire settle high so the outside pull is a fresh edge
    repeat (4) @(negedge core_clk);
    fork
      cjdp_station_i.od_pulse(1'b0);
      pulse_len(1'b0, n);
    join
    check(n == 512, "soft restart length");
    check(nmi_cnt == n0 + 1, "outside nmi");
  endtask
  // Outside hard reset pull starts a device-held sequence
  task automatic t_hard;
    int n;
    // Time the device pulse while the outside pull is still on
    fork
      cjdp_station_i.od_pulse(1'b1);
      pulse_len(1'b1, n);
    join
    check(n == 512, "hard drive length");
    repeat (4) @(negedge core_clk);
    check(hard_reset_n_in === 1'b1 && core_hard_reset === 1'b0,
      "hard release");
  endtask
  initial begin
    resetn = 1'b0;
    core_quiesce_req = 1'b0;
    core_checkstop = 1'b0;
    checkstop_sel = 1'b0;
    shared_bus_pin_n = 1'b1;
    core_soft_reset_req = 1'b0;
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    t_jtag;
    t_pins;
    t_soft;
    t_hard;
    tally_and_finish;
  end
endmodule
`default_nettype wire
